//--- logic/ras_pkg.sv
package ras_pkg;

  // stack geometry
  localparam int unsigned RAS_PC_W = 21;
  localparam int unsigned RAS_SP_W = 5;
  localparam logic [4:0] RAS_SP_EMPTY = 5'h00;
  localparam logic [4:0] RAS_SP_MAX = 5'h1F;
  localparam logic [4:0] RAS_SP_ONE = 5'h01;
  localparam logic [20:0] RAS_PC_STEP = 21'h000002;
  localparam logic [20:0] RAS_PC_ZERO = 21'h000000;

  // register byte addresses on the bus
  localparam logic [7:0] RAS_ADDR_PTR = 8'h00;
  localparam logic [7:0] RAS_ADDR_TOP_ENTRY_LOW_BYTE = 8'h04;
  localparam logic [7:0] RAS_ADDR_TOP_ENTRY_HIGH_BYTE = 8'h08;
  localparam logic [7:0] RAS_ADDR_TOP_ENTRY_UPPER_BYTE = 8'h0C;

  // pointer register layout
  localparam int unsigned RAS_FULL_BIT = 7;
  localparam int unsigned RAS_UNF_BIT = 6;
  localparam int unsigned RAS_SP_LSB = 0;
  localparam int unsigned RAS_SP_MSB = 4;
  localparam int unsigned RAS_UPPER_W = 5;
  localparam logic [7:0] RAS_PTR_RESET = 8'h00;

  // top entry byte lanes
  localparam int unsigned RAS_LOW_LSB = 0;
  localparam int unsigned RAS_HIGH_LSB = 8;
  localparam int unsigned RAS_UPPER_LSB = 16;

  localparam logic [1:0] RAS_HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RAS_WORD_ZERO = 32'h00000000;
  localparam logic [7:0] RAS_BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    RAS_OP_NONE,
    RAS_OP_CALL,
    RAS_OP_CALL_FAST,
    RAS_OP_IRQ,
    RAS_OP_PUSH,
    RAS_OP_RETURN,
    RAS_OP_RETURN_FAST,
    RAS_OP_RETLIT,
    RAS_OP_RETURN_FROM_INTERRUPT,
    RAS_OP_RETURN_FROM_INTERRUPT_FAST,
    RAS_OP_POP
  } ras_op_e;

  typedef enum logic [2:0] {
    RAS_REG_NONE,
    RAS_REG_PTR,
    RAS_REG_TOP_ENTRY_LOW_BYTE,
    RAS_REG_TOP_ENTRY_HIGH_BYTE,
    RAS_REG_TOP_ENTRY_UPPER_BYTE
  } ras_reg_e;

  typedef struct packed {
    ras_op_e op;
    logic [20:0] pc;
  } ras_cmd_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } ras_core_regs_s;

endpackage

//--- logic/ras_return_address_stack.sv
// Behaviour
// - five-bit stack pointer, values 0 to 31
// - push increments then writes; pop reads then decrements
// - any reset zeroes the stack pointer
// - software reads and writes the pointer
// - full flag after 31 pushes without pop
// - flags set by hardware, software only clears
// - enabled: 31st push stores pc+2, resets, zero
// - disabled: pointer stays 31, entry 31 kept
// - empty pop returns zero, sets underflow flag
// - underflow without reset leaves other registers alone
// - enabled faults set flag then request reset
// - push stores current pc in new top
// - pop discards top by decrementing pointer
// - flags bits 7/6, bit 5 zero, pointer 4:0
// - shadow copies hidden, loaded on every interrupt
// - fast interrupt return restores three shadow values
// - later interrupt overwrites earlier shadow copies
// - fast call saves, fast return restores shadows
// - calls and interrupts push, returns pop
// - 31 entries of 21 bits, private storage
// - top entry readable and writable bytewise
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ras_return_address_stack (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // other device resets and stack fault option
  input wire logic device_reset,
  input wire logic stack_fault_reset_enable,
  // instruction sequencer
  input wire ras_pkg::ras_cmd_s cmd,
  input wire ras_pkg::ras_core_regs_s core_regs,
  output logic return_valid,
  output logic [20:0] return_pc,
  output logic restore_valid,
  output ras_pkg::ras_core_regs_s restore_regs,
  // towards reset logic
  output logic fault_reset_req,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // stack state
  logic [4:0] sp;
  logic stack_full_flag;
  logic stack_underflow_flag;
  logic [20:0] entry [ras_pkg::RAS_SP_ONE:ras_pkg::RAS_SP_MAX];
  ras_pkg::ras_core_regs_s shadow;

  // bus data phase
  logic dp_write;
  ras_pkg::ras_reg_e dp_reg;
  logic ap_valid;
  logic [7:0] ptr_byte;

  // next state and strobes
  logic [4:0] next_sp;
  logic [4:0] sp_plus;
  logic [20:0] top_entry;
  logic set_full;
  logic set_unf;
  logic ent_we;
  logic [20:0] ent_data;
  logic ret_go;
  logic [20:0] ret_val;
  logic fault;
  logic is_push;
  logic is_pop;
  logic delivers;
  logic sw_wr_ptr;
  logic sw_wr_tos;
  logic [20:0] tos_wdata;
  logic [4:0] top_idx;
  logic shadow_load;
  logic fast_restore;

  function automatic ras_pkg::ras_reg_e ras_decode(input logic [31:0] addr);
    ras_pkg::ras_reg_e r;
    case (addr[7:0])
      ras_pkg::RAS_ADDR_PTR: begin
        r = ras_pkg::RAS_REG_PTR;
      end
      ras_pkg::RAS_ADDR_TOP_ENTRY_LOW_BYTE: begin
        r = ras_pkg::RAS_REG_TOP_ENTRY_LOW_BYTE;
      end
      ras_pkg::RAS_ADDR_TOP_ENTRY_HIGH_BYTE: begin
        r = ras_pkg::RAS_REG_TOP_ENTRY_HIGH_BYTE;
      end
      ras_pkg::RAS_ADDR_TOP_ENTRY_UPPER_BYTE: begin
        r = ras_pkg::RAS_REG_TOP_ENTRY_UPPER_BYTE;
      end
      default: begin
        r = ras_pkg::RAS_REG_NONE;
      end
    endcase
    return r;
  endfunction

  // merge one written byte into the 21-bit top entry
  function automatic logic [20:0] ras_merge(input ras_pkg::ras_reg_e r, input logic [20:0] old,
                                            input logic [31:0] wd);
    logic [20:0] v;
    v = old;
    case (r)
      ras_pkg::RAS_REG_TOP_ENTRY_LOW_BYTE: begin
        v[ras_pkg::RAS_LOW_LSB +: 8] = wd[7:0];
      end
      ras_pkg::RAS_REG_TOP_ENTRY_HIGH_BYTE: begin
        v[ras_pkg::RAS_HIGH_LSB +: 8] = wd[7:0];
      end
      ras_pkg::RAS_REG_TOP_ENTRY_UPPER_BYTE: begin
        v[ras_pkg::RAS_UPPER_LSB +: ras_pkg::RAS_UPPER_W] = wd[4:0];
      end
      default: begin
        v = old;
      end
    endcase
    return v;
  endfunction

  // readable word of one register; bits beyond the field read as zero
  function automatic logic [31:0] ras_read_word(input ras_pkg::ras_reg_e r, input logic [7:0] ptr,
                                                input logic [20:0] top);
    logic [31:0] w;
    w = ras_pkg::RAS_WORD_ZERO;
    case (r)
      ras_pkg::RAS_REG_PTR: begin
        w[7:0] = ptr;
      end
      ras_pkg::RAS_REG_TOP_ENTRY_LOW_BYTE: begin
        w[7:0] = top[ras_pkg::RAS_LOW_LSB +: 8];
      end
      ras_pkg::RAS_REG_TOP_ENTRY_HIGH_BYTE: begin
        w[7:0] = top[ras_pkg::RAS_HIGH_LSB +: 8];
      end
      ras_pkg::RAS_REG_TOP_ENTRY_UPPER_BYTE: begin
        w[ras_pkg::RAS_UPPER_W - 1:0] = top[ras_pkg::RAS_UPPER_LSB +: ras_pkg::RAS_UPPER_W];
      end
      default: begin
        w = ras_pkg::RAS_WORD_ZERO;
      end
    endcase
    return w;
  endfunction

  // no storage behind pointer zero, it is only the reset value; the index never leaves the array
  assign top_idx = (sp == ras_pkg::RAS_SP_EMPTY) ? ras_pkg::RAS_SP_ONE : sp;
  assign top_entry = (sp == ras_pkg::RAS_SP_EMPTY) ? ras_pkg::RAS_PC_ZERO : entry[top_idx];
  assign ptr_byte = {stack_full_flag, stack_underflow_flag, 1'b0, sp};
  assign shadow_load = (cmd.op == ras_pkg::RAS_OP_IRQ) || (cmd.op == ras_pkg::RAS_OP_CALL_FAST);
  assign fast_restore = (cmd.op == ras_pkg::RAS_OP_RETURN_FROM_INTERRUPT_FAST) || (cmd.op == ras_pkg::RAS_OP_RETURN_FAST);
  assign sp_plus = 5'(sp + ras_pkg::RAS_SP_ONE);
  assign ap_valid = hsel && (htrans == ras_pkg::RAS_HTRANS_NONSEQ) && hready;
  assign sw_wr_ptr = dp_write && (dp_reg == ras_pkg::RAS_REG_PTR);
  assign sw_wr_tos = dp_write && (dp_reg != ras_pkg::RAS_REG_PTR) && (dp_reg != ras_pkg::RAS_REG_NONE)
                     && (sp != ras_pkg::RAS_SP_EMPTY);
  assign tos_wdata = ras_merge(dp_reg, top_entry, hwdata);

  always_comb begin
    is_push = 1'b0;
    is_pop = 1'b0;
    delivers = 1'b0;
    case (cmd.op)
      ras_pkg::RAS_OP_CALL,
      ras_pkg::RAS_OP_CALL_FAST,
      ras_pkg::RAS_OP_IRQ,
      ras_pkg::RAS_OP_PUSH: begin
        is_push = 1'b1;
      end
      ras_pkg::RAS_OP_RETURN,
      ras_pkg::RAS_OP_RETURN_FAST,
      ras_pkg::RAS_OP_RETLIT,
      ras_pkg::RAS_OP_RETURN_FROM_INTERRUPT,
      ras_pkg::RAS_OP_RETURN_FROM_INTERRUPT_FAST: begin
        is_pop = 1'b1;
        delivers = 1'b1;
      end
      ras_pkg::RAS_OP_POP: begin
        is_pop = 1'b1;
      end
      default: begin
        is_push = 1'b0;
      end
    endcase
  end

  // stack sequencing; sequencer wins over a same-cycle software pointer write
  always_comb begin
    next_sp = sp;
    set_full = 1'b0;
    set_unf = 1'b0;
    ent_we = 1'b0;
    ent_data = cmd.pc;
    ret_go = 1'b0;
    ret_val = ras_pkg::RAS_PC_ZERO;
    fault = 1'b0;
    if (device_reset) begin
      next_sp = ras_pkg::RAS_SP_EMPTY;
    end else if (is_push) begin
      if (sp == ras_pkg::RAS_SP_MAX) begin
        // a push at pointer 31 leaves entry 31 unchanged
        set_full = 1'b1;
        fault = stack_fault_reset_enable;
      end else begin
        ent_we = 1'b1;
        next_sp = sp_plus;
        if (sp_plus == ras_pkg::RAS_SP_MAX) begin
          set_full = 1'b1;
          if (stack_fault_reset_enable) begin
            ent_data = 21'(cmd.pc + ras_pkg::RAS_PC_STEP);
            next_sp = ras_pkg::RAS_SP_EMPTY;
            fault = 1'b1;
          end
        end
      end
    end else if (is_pop) begin
      if (sp == ras_pkg::RAS_SP_EMPTY) begin
        set_unf = 1'b1;
        ret_go = delivers;
        fault = stack_fault_reset_enable;
      end else begin
        ret_go = delivers;
        ret_val = top_entry;
        next_sp = 5'(sp - ras_pkg::RAS_SP_ONE);
      end
    end else if (sw_wr_ptr) begin
      next_sp = hwdata[ras_pkg::RAS_SP_MSB:ras_pkg::RAS_SP_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= ras_pkg::RAS_PTR_RESET[ras_pkg::RAS_SP_MSB:ras_pkg::RAS_SP_LSB];
    end else begin
      sp <= next_sp;
    end
  end

  // flags survive non power-on resets; set beats a clearing write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_full_flag <= 1'b0;
    end else if (set_full) begin
      stack_full_flag <= 1'b1;
    end else if (sw_wr_ptr) begin
      stack_full_flag <= stack_full_flag & hwdata[ras_pkg::RAS_FULL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_underflow_flag <= 1'b0;
    end else if (set_unf) begin
      stack_underflow_flag <= 1'b1;
    end else if (sw_wr_ptr) begin
      stack_underflow_flag <= stack_underflow_flag & hwdata[ras_pkg::RAS_UNF_BIT];
    end
  end

  // 31 private entries; push beats a software top-entry write
  genvar gi;
  generate
    for (gi = ras_pkg::RAS_SP_ONE; gi <= ras_pkg::RAS_SP_MAX; gi++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          entry[gi] <= ras_pkg::RAS_PC_ZERO;
        end else if (ent_we && (sp_plus == 5'(gi))) begin
          entry[gi] <= ent_data;
        end else if (sw_wr_tos && !is_push && !is_pop && (sp == 5'(gi))) begin
          entry[gi] <= tos_wdata;
        end
      end
    end
  endgenerate

  // shadow registers, invisible to the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= '0;
    end else if (shadow_load) begin
      shadow <= core_regs;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restore_valid <= 1'b0;
    end else begin
      restore_valid <= fast_restore;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restore_regs <= '0;
    end else begin
      restore_regs <= shadow;
    end
  end

  // return address towards the program counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      return_valid <= 1'b0;
    end else begin
      return_valid <= ret_go;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      return_pc <= ras_pkg::RAS_PC_ZERO;
    end else begin
      return_pc <= ret_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reset_req <= 1'b0;
    end else begin
      fault_reset_req <= fault;
    end
  end

  // bus: zero wait states, always okay; data phase state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_reg <= ras_pkg::RAS_REG_NONE;
    end else if (hready) begin
      dp_write <= ap_valid && hwrite;
      dp_reg <= ap_valid ? ras_decode(haddr) : ras_pkg::RAS_REG_NONE;
    end
  end

  // never stretches a transfer, so every access has a single data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // unmapped offsets are answered okay as well
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // read data captured at the address phase edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= ras_pkg::RAS_WORD_ZERO;
    end else if (ap_valid && !hwrite) begin
      hrdata <= ras_read_word(ras_decode(haddr), ptr_byte, top_entry);
    end
  end

endmodule

`default_nettype wire

//--- tb/ras_return_address_stack_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ras_return_address_stack_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sequencer side
  input wire logic device_reset,
  input wire logic stack_fault_reset_enable,
  input wire ras_pkg::ras_cmd_s cmd,
  input wire logic return_valid,
  input wire logic restore_valid,
  input wire logic fault_reset_req,
  // bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd_take;
  logic ret_op;
  logic fast_op;
  assign rd_take = hsel && htrans == ras_pkg::RAS_HTRANS_NONSEQ && hready && !hwrite;
  assign ret_op = cmd.op inside {[ras_pkg::RAS_OP_RETURN:ras_pkg::RAS_OP_RETURN_FROM_INTERRUPT_FAST]};
  assign fast_op = cmd.op inside {ras_pkg::RAS_OP_RETURN_FAST, ras_pkg::RAS_OP_RETURN_FROM_INTERRUPT_FAST};
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  ret_pulse_a: assert property (ret_op && !device_reset |=> return_valid) else $error("no return");
  ret_cause_a: assert property (return_valid |-> $past(ret_op)) else $error("stray return");
  restore_on_a: assert property (fast_op && !device_reset |=> restore_valid) else $error("no restore");
  restore_why_a: assert property (restore_valid |-> $past(fast_op)) else $error("stray restore");
  fault_cause_a: assert property (fault_reset_req |-> $past(stack_fault_reset_enable)
    && $past(cmd.op) != ras_pkg::RAS_OP_NONE) else $error("fault request without cause");
  ptr_layout_a: assert property (rd_take && haddr[7:0] == ras_pkg::RAS_ADDR_PTR
    |=> hrdata[31:8] == 24'h000000 && !hrdata[5]) else $error("pointer layout");
  upper_width_a: assert property (rd_take && haddr[7:0] == ras_pkg::RAS_ADDR_TOP_ENTRY_UPPER_BYTE
    |=> hrdata[31:5] == 27'h0000000) else $error("upper byte width");
  unmapped_zero_a: assert property (rd_take && haddr[7:0] == 8'h10
    |=> hrdata == ras_pkg::RAS_WORD_ZERO) else $error("unmapped read");
endmodule
bind ras_return_address_stack ras_return_address_stack_properties ras_props_inst (.clk, .rst_n,
  .device_reset, .stack_fault_reset_enable, .cmd, .return_valid, .restore_valid, .fault_reset_req,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp);
`default_nettype wire

//--- tb/ras_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module ras_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // answers from the stack
  input wire logic return_valid,
  input wire logic [20:0] return_pc,
  input wire logic restore_valid,
  input wire ras_pkg::ras_core_regs_s restore_regs,
  input wire logic fault_reset_req,
  // requests to the stack
  output var ras_pkg::ras_cmd_s cmd,
  output var ras_pkg::ras_core_regs_s core_regs,
  output logic device_reset
);
  logic ret_seen;
  logic [20:0] ret_pc;
  logic rest_seen;
  ras_pkg::ras_core_regs_s rest_regs;
  logic fault_seen;
  initial begin
    cmd = '0;
    core_regs = '0;
  end
  // reset logic loops the request back, one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= fault_reset_req;
    end
  end
  task automatic issue(input ras_pkg::ras_op_e op, input logic [20:0] pc, input ras_pkg::ras_core_regs_s r);
    @(posedge clk);
    cmd.op <= op;
    cmd.pc <= {pc[20:1], 1'b0};
    core_regs <= r;
    @(posedge clk);
    cmd.op <= ras_pkg::RAS_OP_NONE;
    #1;
    ret_seen = return_valid;
    ret_pc = return_pc;
    rest_seen = restore_valid;
    rest_regs = restore_regs;
    fault_seen = fault_reset_req;
  endtask
endmodule
`default_nettype wire

//--- tb/ras_return_address_stack_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ras_return_address_stack_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stack_fault_reset_enable = 1'b0;
  logic device_reset;
  ras_pkg::ras_cmd_s cmd;
  ras_pkg::ras_core_regs_s core_regs;
  ras_pkg::ras_core_regs_s regs = '0;
  logic return_valid;
  logic [20:0] return_pc;
  logic restore_valid;
  ras_pkg::ras_core_regs_s restore_regs;
  logic fault_reset_req;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  int errors = 0;
  int cmp_count = 0;
  // one slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #2 clk = ~clk;
  ras_return_address_stack ras_return_address_stack_inst (.clk, .rst_n, .device_reset,
    .stack_fault_reset_enable, .cmd, .core_regs, .return_valid, .return_pc, .restore_valid,
    .restore_regs, .fault_reset_req, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp);
  ras_seq_model ras_seq_model_inst (.clk, .rst_n, .return_valid, .return_pc, .restore_valid,
    .restore_regs, .fault_reset_req, .cmd, .core_regs, .device_reset);
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= ras_pkg::RAS_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, e, "register read");
  endtask
  task automatic op(input ras_pkg::ras_op_e o, input logic [20:0] pc);
    ras_seq_model_inst.issue(o, pc, regs);
  endtask
  task automatic ret(input logic [20:0] pc);
    chk({ras_seq_model_inst.ret_seen, 10'h000, ras_seq_model_inst.ret_pc}, {1'b1, 10'h000, pc}, "return");
  endtask
  task automatic flt(input logic v);
    chk({31'h00000000, ras_seq_model_inst.fault_seen}, {31'h00000000, v}, "fault request");
  endtask
  task automatic t_basic();
    rd(8'h00, 32'h00000000);
    op(ras_pkg::RAS_OP_CALL, 21'h000100);
    op(ras_pkg::RAS_OP_PUSH, 21'h002468);
    op(ras_pkg::RAS_OP_IRQ, 21'h01ABCE);
    rd(8'h00, 32'h00000003);
    rd(8'h04, 32'h000000CE);
    rd(8'h08, 32'h000000AB);
    rd(8'h0C, 32'h00000001);
    rd(8'h10, 32'h00000000);
    op(ras_pkg::RAS_OP_RETURN, 21'h000000);
    ret(21'h01ABCE);
    op(ras_pkg::RAS_OP_POP, 21'h000000);
    rd(8'h00, 32'h00000001);
    rd(8'h08, 32'h00000001);
    $display("basic push and pop done");
  endtask
  task automatic t_soft();
    // popped entry 2 is still held, so pointer write exposes it
    wr(8'h00, 32'h00000002);
    rd(8'h00, 32'h00000002);
    wr(8'h04, 32'h00000034);
    op(ras_pkg::RAS_OP_RETURN, 21'h000000);
    ret(21'h002434);
    op(ras_pkg::RAS_OP_RETLIT, 21'h000000);
    ret(21'h000100);
    $display("software access done");
  endtask
  task automatic t_unf();
    op(ras_pkg::RAS_OP_RETURN, 21'h000000);
    ret(21'h000000);
    flt(1'b0);
    rd(8'h00, 32'h00000040);
    wr(8'h00, 32'h000000C0);
    rd(8'h00, 32'h00000040);
    wr(8'h00, 32'h00000000);
    rd(8'h00, 32'h00000000);
    $display("underflow done");
  endtask
  task automatic t_full_off();
    for (int i = 1; i <= 31; i++) op(ras_pkg::RAS_OP_CALL, 21'h000200 + 21'(2 * i));
    flt(1'b0);
    rd(8'h00, 32'h0000009F);
    op(ras_pkg::RAS_OP_CALL, 21'h0003FE);
    rd(8'h00, 32'h0000009F);
    rd(8'h04, 32'h0000003E);
    rd(8'h08, 32'h00000002);
    wr(8'h00, 32'h00000000);
    $display("full without reset done");
  endtask
  task automatic t_full_on();
    @(posedge clk);
    stack_fault_reset_enable <= 1'b1;
    for (int i = 1; i <= 31; i++) op(ras_pkg::RAS_OP_CALL, 21'h000400 + 21'(2 * i));
    flt(1'b1);
    repeat (4) @(posedge clk);
    rd(8'h00, 32'h00000080);
    wr(8'h00, 32'h0000009F);
    rd(8'h04, 32'h00000040);
    wr(8'h00, 32'h00000080);
    op(ras_pkg::RAS_OP_RETURN, 21'h000000);
    flt(1'b1);
    repeat (4) @(posedge clk);
    rd(8'h00, 32'h000000C0);
    @(posedge clk);
    rst_n <= 1'b0;
    stack_fault_reset_enable <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h00000000);
    $display("full with reset done");
  endtask
  task automatic t_shadow();
    regs = 24'h112233;
    op(ras_pkg::RAS_OP_IRQ, 21'h000500);
    regs = 24'h445566;
    op(ras_pkg::RAS_OP_IRQ, 21'h000502);
    regs = 24'h000000;
    op(ras_pkg::RAS_OP_RETURN_FROM_INTERRUPT_FAST, 21'h000000);
    chk({7'h00, ras_seq_model_inst.rest_seen, ras_seq_model_inst.rest_regs}, 32'h01445566, "shadow");
    op(ras_pkg::RAS_OP_RETURN_FROM_INTERRUPT, 21'h000000);
    chk({31'h00000000, ras_seq_model_inst.rest_seen}, 32'h00000000, "plain return");
    regs = 24'h778899;
    op(ras_pkg::RAS_OP_CALL_FAST, 21'h000600);
    regs = 24'h000000;
    op(ras_pkg::RAS_OP_RETURN_FAST, 21'h000000);
    chk({7'h00, ras_seq_model_inst.rest_seen, ras_seq_model_inst.rest_regs}, 32'h01778899, "fast call");
    ret(21'h000600);
    $display("shadow done");
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_basic();
    t_soft();
    t_unf();
    t_full_off();
    t_full_on();
    t_shadow();
    report_and_stop();
  end
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
